// ==== eicx_top.sv ====
// External pin interrupt, wake control and context save for an 8-bit core.
// Assumes the core reports halt, retired instructions and return from
// interrupt as signals on ref_clk; the pin is asynchronous.
`timescale 1ns/1ps

module eicx_top
	import eicx_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire eicx_bus_req_t     bus_req,
	output logic [DATA_W-1:0]      bus_rdata,
	input  wire logic              ext_int_pin,
	input  wire logic              halt_active,
	input  wire logic              instr_retire,
	input  wire logic              isr_return,
	input  wire logic [PC_W-1:0]   ret_pc,
	input  wire eicx_ctx_t         live_ctx,
	output logic                   wake_req,
	output logic                   vector_req,
	output logic                   push_valid,
	output logic [PC_W-1:0]        push_pc,
	output logic                   restore_valid,
	output eicx_ctx_t              restore_ctx,
	output logic                   irq
);

	// ------------------------------------------------------------------
	// Pin synchroniser and edge filter
	// ------------------------------------------------------------------
	// Three stages, registered below with the rest; the level only moves
	// once stages two and three agree, so a one-cycle glitch is dropped
	logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic pin_lvl_reg, pin_lvl_next;
	logic edge_hit;

	// ------------------------------------------------------------------
	// Registers and control state
	// ------------------------------------------------------------------
	eicx_state_t       state_reg, state_next;
	logic [DATA_W-1:0] int_control_reg_reg, int_control_reg_next;
	logic [DATA_W-1:0] edge_reg, edge_next;
	logic [DATA_W-1:0] peripheral_enable_two_reg, peripheral_enable_two_next;
	logic [DATA_W-1:0] peripheral_flags_two_reg, peripheral_flags_two_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic              irq_reg, irq_next;
	logic              wake_reg, wake_next;
	logic              vec_reg, vec_next;
	logic              push_v_reg, push_v_next;
	logic [PC_W-1:0]   push_pc_reg, push_pc_next;
	logic              rest_v_reg, rest_v_next;
	eicx_ctx_t         rest_ctx_reg, rest_ctx_next;
	eicx_ctx_t         shadow_ctx;
	logic              entry;
	logic              take_int;
	logic              wake_src;
	logic              sh_hit;
	logic [SH_IW-1:0]  sh_idx;
	logic [6:0]        sh_off;
	logic [DATA_W-1:0] ev;

	// Shadow window decode in bank 31
	always_comb
	begin
		sh_off = bus_req.addr[6:0] - SHADOW_BASE;
		sh_idx = sh_off[SH_IW-1:0];
		sh_hit = (bus_req.addr[ADDR_W-1:7] == SHADOW_BANK)
		      && (bus_req.addr[6:0] >= SHADOW_BASE)
		      && (sh_off < 7'(SH_NUM));
	end

	eicx_shadow u_shadow (
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.capture    (entry),
		.live_ctx   (live_ctx),
		.sw_wr      (bus_req.wr && sh_hit),
		.sw_idx     (sh_idx),
		.sw_wdata   (bus_req.wdata),
		.shadow_ctx (shadow_ctx)
	);

	// Interrupt decisions from registered state
	always_comb
	begin
		// Pin path is the only wake source: its flag is set through the ref_clk synchroniser
		wake_src = int_control_reg_reg[EXT_INT_FLAG_BIT] && int_control_reg_reg[EXT_INT_ENABLE_BIT];
		take_int = wake_src && int_control_reg_reg[GIE_BIT];
		case (state_reg)
			ST_RUN:       entry = take_int;
			ST_WAKE_STEP: entry = take_int && instr_retire;
			default:      entry = 1'b0;
		endcase
	end

	// Next values of every register except the three pin synchroniser stages
	always_comb
	begin
		pin_lvl_next  = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_lvl_reg;
		edge_hit      = (pin_lvl_next != pin_lvl_reg)
		             && (edge_reg[EDGE_BIT] ? pin_lvl_next
		                                    : !pin_lvl_next);
		state_next    = state_reg;
		int_control_reg_next   = int_control_reg_reg;
		edge_next     = edge_reg;
		peripheral_enable_two_next     = peripheral_enable_two_reg;
		peripheral_flags_two_next     = peripheral_flags_two_reg;
		rdata_next    = ZERO_BYTE;
		wake_next     = 1'b0;
		vec_next      = 1'b0;
		push_v_next   = 1'b0;
		push_pc_next  = push_pc_reg;
		rest_v_next   = 1'b0;
		rest_ctx_next = rest_ctx_reg;
		ev            = ZERO_BYTE;

		// Software access first, so hardware updates below take priority
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				ADDR_INT_CONTROL:
				begin
					int_control_reg_next = (int_control_reg_reg & ~INT_CONTROL_REG_WMASK)
					            | (bus_req.wdata & INT_CONTROL_REG_WMASK);
					// Flag is write one to clear
					if (bus_req.wdata[EXT_INT_FLAG_BIT])
						int_control_reg_next[EXT_INT_FLAG_BIT] = 1'b0;
				end
				ADDR_EDGE_CTRL: edge_next = bus_req.wdata & EDGE_WMASK;
				ADDR_PERIPHERAL_ENABLE_TWO:      peripheral_enable_two_next = bus_req.wdata & EV_MASK;
				ADDR_PERIPHERAL_FLAGS_TWO:      peripheral_flags_two_next = peripheral_flags_two_reg & ~bus_req.wdata;
				default:        ;
			endcase
		end
		if (bus_req.rd)
		begin
			if (sh_hit)
				rdata_next = shadow_ctx[sh_idx*DATA_W +: DATA_W];
			else
			begin
				case (bus_req.addr)
					ADDR_INT_CONTROL: rdata_next = int_control_reg_reg;
					ADDR_EDGE_CTRL:   rdata_next = edge_reg;
					ADDR_PERIPHERAL_ENABLE_TWO:        rdata_next = peripheral_enable_two_reg;
					ADDR_PERIPHERAL_FLAGS_TWO:        rdata_next = peripheral_flags_two_reg;
					default:          rdata_next = ZERO_BYTE;
				endcase
			end
		end

		// Valid edge sets the flag whatever the enables; set beats clear
		if (edge_hit)
		begin
			int_control_reg_next[EXT_INT_FLAG_BIT] = 1'b1;
			ev[EV_EDGE]           = 1'b1;
		end

		// Core sequencing
		case (state_reg)
			ST_RUN:
			begin
				// Halt level lags the wake pulse a cycle; no false re-halt
				if (!take_int && halt_active && !wake_reg)
					state_next = ST_HALT;
			end
			ST_HALT:
			begin
				if (wake_src)
				begin
					wake_next     = 1'b1;
					ev[EV_WAKE]   = 1'b1;
					// Vector only with global enable, else plain resume
					state_next    = int_control_reg_reg[GIE_BIT] ? ST_WAKE_STEP
					                                    : ST_RUN;
				end
			end
			ST_WAKE_STEP:
			begin
				// Enables may have dropped while waiting for the retire
				if (instr_retire && !take_int)
					state_next = ST_RUN;
			end
			ST_ISR:
			begin
				if (isr_return)
				begin
					rest_v_next            = 1'b1;
					rest_ctx_next          = shadow_ctx;
					int_control_reg_next[GIE_BIT]   = 1'b1;
					ev[EV_EXIT]            = 1'b1;
					state_next             = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase

		// Entry: flag is left alone, only global enable drops
		if (entry)
		begin
			vec_next             = 1'b1;
			push_v_next          = 1'b1;
			push_pc_next         = ret_pc;
			int_control_reg_next[GIE_BIT] = 1'b0;
			ev[EV_ENTRY]         = 1'b1;
			state_next           = ST_ISR;
		end

		peripheral_flags_two_next = peripheral_flags_two_next | ev;
		irq_next  = |(peripheral_flags_two_next & peripheral_enable_two_next);
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_s1_reg   <= 1'b0;
			pin_s2_reg   <= 1'b0;
			pin_s3_reg   <= 1'b0;
			pin_lvl_reg  <= 1'b0;
			state_reg    <= ST_RUN;
			int_control_reg_reg   <= INT_CONTROL_REG_RST;
			edge_reg     <= EDGE_RST;
			peripheral_enable_two_reg     <= ZERO_BYTE;
			peripheral_flags_two_reg     <= ZERO_BYTE;
			rdata_reg    <= ZERO_BYTE;
			irq_reg      <= 1'b0;
			wake_reg     <= 1'b0;
			vec_reg      <= 1'b0;
			push_v_reg   <= 1'b0;
			push_pc_reg  <= '0;
			rest_v_reg   <= 1'b0;
			rest_ctx_reg <= '0;
		end
		else
		begin
			pin_s1_reg   <= ext_int_pin;
			pin_s2_reg   <= pin_s1_reg;
			pin_s3_reg   <= pin_s2_reg;
			pin_lvl_reg  <= pin_lvl_next;
			state_reg    <= state_next;
			int_control_reg_reg   <= int_control_reg_next;
			edge_reg     <= edge_next;
			peripheral_enable_two_reg     <= peripheral_enable_two_next;
			peripheral_flags_two_reg     <= peripheral_flags_two_next;
			rdata_reg    <= rdata_next;
			irq_reg      <= irq_next;
			wake_reg     <= wake_next;
			vec_reg      <= vec_next;
			push_v_reg   <= push_v_next;
			push_pc_reg  <= push_pc_next;
			rest_v_reg   <= rest_v_next;
			rest_ctx_reg <= rest_ctx_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all registered
	// ------------------------------------------------------------------
	assign bus_rdata     = rdata_reg;
	assign irq           = irq_reg;
	assign wake_req      = wake_reg;
	assign vector_req    = vec_reg;
	assign push_valid    = push_v_reg;
	assign push_pc       = push_pc_reg;
	assign restore_valid = rest_v_reg;
	assign restore_ctx   = rest_ctx_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_flag_on_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
		edge_hit |=> int_control_reg_reg[EXT_INT_FLAG_BIT])
		else $error("flag missed a valid edge");
	a_rise_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
		(edge_reg[EDGE_BIT] && !pin_lvl_reg && pin_lvl_next) |-> edge_hit)
		else $error("rising edge not taken");
	a_fall_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!edge_reg[EDGE_BIT] && pin_lvl_reg && !pin_lvl_next) |-> edge_hit)
		else $error("falling edge not taken");
	a_vector_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(vector_req) |-> $past(int_control_reg_reg[GIE_BIT])
		&& $past(int_control_reg_reg[EXT_INT_ENABLE_BIT]) && $past(int_control_reg_reg[EXT_INT_FLAG_BIT]))
		else $error("vector without flag and enables");
	a_push_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
		entry |=> push_valid && vector_req && push_pc == $past(ret_pc))
		else $error("return address not pushed on entry");
	a_restore_ctx: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_ISR && isr_return)
		|=> restore_valid && restore_ctx == $past(shadow_ctx))
		else $error("context not restored from shadow");
	a_wake_retire: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_WAKE_STEP && !instr_retire) |=> !vector_req)
		else $error("vector before post-halt instruction");
	a_wake_gie: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_reg == ST_HALT && wake_src && !int_control_reg_reg[GIE_BIT])
		|=> wake_req && state_reg == ST_RUN)
		else $error("wake without global enable must resume");
	a_flag_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
		(entry && !bus_req.wr) |=> int_control_reg_reg[EXT_INT_FLAG_BIT])
		else $error("flag cleared by vectoring");
	a_wake_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
		wake_req |-> $past(int_control_reg_reg[EXT_INT_ENABLE_BIT]))
		else $error("wake from a disabled source");

	c_wake_vector: cover property (@(posedge ref_clk) disable iff (!rstn)
		wake_req ##[1:20] vector_req);
	c_run_entry: cover property (@(posedge ref_clk) disable iff (!rstn)
		vector_req ##[1:50] restore_valid);
	c_plain_wake: cover property (@(posedge ref_clk) disable iff (!rstn)
		wake_req && state_reg == ST_RUN);

endmodule

// ==== eicx_pkg.sv ====
// Constants, field layouts and carrier types for the external pin
// interrupt and context save block.
// Assumes an 8-bit core with a 12-bit banked data address space.
package eicx_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int PC_W   = 15;
	localparam int SH_NUM = 8;
	localparam int SH_IW  = 3;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_INT_CONTROL = 12'h00B;
	localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_FLAGS_TWO        = 12'h012;
	localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_ENABLE_TWO        = 12'h092;
	localparam logic [ADDR_W-1:0] ADDR_EDGE_CTRL   = 12'h095;
	localparam logic [4:0]        SHADOW_BANK      = 5'h1F;
	localparam logic [6:0]        SHADOW_BASE      = 7'h64;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int GIE_BIT  = 7;
	localparam int PERIPH_INT_ENABLE_BIT = 6;
	localparam int EXT_INT_ENABLE_BIT = 4;
	localparam int EXT_INT_FLAG_BIT = 1;
	localparam int EDGE_BIT = 6;
	localparam int EV_EDGE  = 0;
	localparam int EV_WAKE  = 1;
	localparam int EV_ENTRY = 2;
	localparam int EV_EXIT  = 3;

	// ------------------------------------------------------------------
	// Masks and reset values
	// ------------------------------------------------------------------
	localparam logic [DATA_W-1:0] INT_CONTROL_REG_WMASK  = 8'hD0;
	localparam logic [DATA_W-1:0] EDGE_WMASK    = 8'h40;
	localparam logic [DATA_W-1:0] EV_MASK       = 8'h0F;
	localparam logic [DATA_W-1:0] STATUS_KEEP   = 8'hE7;
	localparam logic [DATA_W-1:0] INT_CONTROL_REG_RST    = 8'h00;
	localparam logic [DATA_W-1:0] EDGE_RST      = 8'h40;
	localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} eicx_bus_req_t;

	// Lowest byte is shadow index 0
	typedef struct packed {
		logic [DATA_W-1:0] w_acc;
		logic [DATA_W-1:0] status;
		logic [DATA_W-1:0] bank_select_reg;
		logic [DATA_W-1:0] ptr0_lo;
		logic [DATA_W-1:0] ptr0_hi;
		logic [DATA_W-1:0] ptr1_lo;
		logic [DATA_W-1:0] ptr1_hi;
		logic [DATA_W-1:0] pc_high_latch;
	} eicx_ctx_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_HALT,
		ST_WAKE_STEP,
		ST_ISR
	} eicx_state_t;

endpackage

// ==== eicx_shadow.sv ====
// Shadow copies of the core context, saved on interrupt entry.
// Assumes capture and software write come from logic on ref_clk.
`timescale 1ns/1ps

module eicx_shadow
	import eicx_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic              capture,
	input  wire eicx_ctx_t         live_ctx,
	input  wire logic              sw_wr,
	input  wire logic [SH_IW-1:0]  sw_idx,
	input  wire logic [DATA_W-1:0] sw_wdata,
	output eicx_ctx_t              shadow_ctx
);

	// ------------------------------------------------------------------
	// Shadow storage
	// ------------------------------------------------------------------
	eicx_ctx_t sh_reg;
	eicx_ctx_t sh_next;

	// Capture wins over a software write in the same cycle
	always_comb
	begin
		sh_next = sh_reg;
		if (capture)
		begin
			sh_next        = live_ctx;
			sh_next.status = live_ctx.status & STATUS_KEEP;
		end
		else if (sw_wr)
			sh_next[sw_idx*DATA_W +: DATA_W] = sw_wdata;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			sh_reg <= '0;
		else
			sh_reg <= sh_next;
	end

	assign shadow_ctx = sh_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_status_masked: assert property (@(posedge ref_clk) disable iff (!rstn)
		capture |=> (sh_reg.status & ~STATUS_KEEP) == ZERO_BYTE)
		else $error("saved status keeps timeout or power-down bit");

	a_capture_acc: assert property (@(posedge ref_clk) disable iff (!rstn)
		capture |=> sh_reg.w_acc == $past(live_ctx.w_acc))
		else $error("accumulator not saved on entry");

endmodule

// ==== eicx_core_model.sv ====
// Behavioural processor core facing the interrupt block.
// Assumes the bench pulses go_halt and go_ret for one ref_clk cycle.
`timescale 1ns/1ps

module eicx_core_model
	import eicx_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       wake_req,
	input  wire logic       restore_valid,
	input  wire eicx_ctx_t  restore_ctx,
	input  wire logic       go_halt,
	input  wire logic       go_ret,
	output logic            halt_active,
	output logic            instr_retire,
	output logic            isr_return,
	output logic [PC_W-1:0] ret_pc,
	output eicx_ctx_t       live_ctx
);
	logic [1:0] step_cnt;

	// ------------------------------------------------------------------
	// Core sequencing
	// ------------------------------------------------------------------
	// Halts only on request; the bench sets the enable beforehand
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			halt_active  <= 1'b0;
			instr_retire <= 1'b0;
			isr_return   <= 1'b0;
			step_cnt     <= 2'h0;
			ret_pc       <= 15'h0100;
			live_ctx     <= 64'hFEDC_BA98_7654_3210;
		end
		else
		begin
			// One instruction retires three cycles after a wake
			instr_retire <= (step_cnt == 2'h1);
			isr_return   <= go_ret;
			if (wake_req)
				halt_active <= 1'b0;
			else if (go_halt)
				halt_active <= 1'b1;
			step_cnt <= wake_req ? 2'h2 : step_cnt - {1'b0, |step_cnt};
			if (step_cnt == 2'h1)
				ret_pc <= ret_pc + 15'h1;
			// Live values scrambled so a stale restore shows up
			if (restore_valid)
				live_ctx <= restore_ctx;
			else if (instr_retire)
				live_ctx <= {live_ctx[55:0], live_ctx[63:56] + 8'h11};
		end
	end
endmodule

// ==== eicx_top_test.sv ====
// Self-checking bench for the pin interrupt and context save block.
// Assumes the core model answers wakes and the bench drives the bus.
`timescale 1ns/1ps

module eicx_top_test
	import eicx_pkg::*;
;
	logic              ref_clk     = 1'b0;
	logic              rstn        = 1'b0;
	eicx_bus_req_t     bus_req     = '0;
	logic              ext_int_pin = 1'b0;
	logic              go_halt     = 1'b0;
	logic              go_ret      = 1'b0;
	logic              retired     = 1'b1;
	logic [DATA_W-1:0] bus_rdata;
	logic              halt_active;
	logic              instr_retire;
	logic              isr_return;
	logic [PC_W-1:0]   ret_pc;
	logic [PC_W-1:0]   prev_pc;
	logic [PC_W-1:0]   push_pc;
	eicx_ctx_t         live_ctx;
	eicx_ctx_t         prev_ctx;
	eicx_ctx_t         exp_ctx;
	eicx_ctx_t         restore_ctx;
	eicx_ctx_t         exp_q[$];
	logic              wake_req;
	logic              vector_req;
	logic              push_valid;
	logic              restore_valid;
	logic              irq;
	logic [2:0]        idx;
	logic [7:0]        rnd;
	logic [ADDR_W-1:0] sh_a;
	int                errors      = 0;
	int                tests_run   = 0;
	int                vec_cnt     = 0;
	int                wake_cnt    = 0;
	int                n;
	int                w;
	int                seed        = 62194;

	always #2.5 ref_clk = ~ref_clk;

	eicx_top dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .ext_int_pin(ext_int_pin),
		.halt_active(halt_active), .instr_retire(instr_retire),
		.isr_return(isr_return), .ret_pc(ret_pc), .live_ctx(live_ctx),
		.wake_req(wake_req), .vector_req(vector_req),
		.push_valid(push_valid), .push_pc(push_pc),
		.restore_valid(restore_valid), .restore_ctx(restore_ctx),
		.irq(irq));

	eicx_core_model core (.ref_clk(ref_clk), .rstn(rstn),
		.wake_req(wake_req), .restore_valid(restore_valid),
		.restore_ctx(restore_ctx), .go_halt(go_halt), .go_ret(go_ret),
		.halt_active(halt_active), .instr_retire(instr_retire),
		.isr_return(isr_return), .ret_pc(ret_pc), .live_ctx(live_ctx));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e,
		input string what);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		#1 chk(bus_rdata, e, what);
	endtask

	// Falling edge first, then a rising edge settled past the synchroniser
	task automatic pin_rise;
		@(posedge ref_clk) ext_int_pin <= 1'b0;
		cyc(6);
		ext_int_pin <= 1'b1;
		cyc(8);
	endtask

	task automatic ret_pulse;
		@(posedge ref_clk) go_ret <= 1'b1;
		@(posedge ref_clk) go_ret <= 1'b0;
		cyc(4);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Reference model: entry captures, restores and wake order
	// ------------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		if (vector_req === 1'b1)
		begin
			vec_cnt++;
			exp_ctx = prev_ctx;
			exp_ctx.status = prev_ctx.status & STATUS_KEEP;
			exp_q.push_back(exp_ctx);
			chk(push_valid, 1'b1, "push beside vector");
			chk(push_pc, prev_pc, "pushed address");
			chk(retired, 1'b1, "vector before retire");
		end
		if (restore_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(1'b0, 1'b1, "restore without entry");
			else
				chk(restore_ctx, exp_q.pop_front(), "restored ctx");
		end
		if (wake_req === 1'b1)
			wake_cnt++;
		if (instr_retire === 1'b1)
			retired = 1'b1;
		prev_ctx = live_ctx;
		prev_pc  = ret_pc;
	end

	// Tests need under a thousand cycles; twenty thousand means a hang
	initial
	begin
		#100000;
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		cyc(12);
		rstn <= 1'b1;
		rd_chk(ADDR_INT_CONTROL, INT_CONTROL_REG_RST, "control reset");
		rd_chk(ADDR_EDGE_CTRL, EDGE_RST, "edge select reset");
		wr_reg(12'h300, 8'hFF);
		rd_chk(12'h300, ZERO_BYTE, "unmapped read");
		// Unused control bits must neither store nor read back
		wr_reg(ADDR_INT_CONTROL, 8'h25);
		rd_chk(ADDR_INT_CONTROL, ZERO_BYTE, "reserved bits");
		$display("test reset done");
		// Wrong edge first, then the selected one
		for (int sel = 0; sel < 2; sel++)
		begin
			wr_reg(ADDR_EDGE_CTRL, sel[0] ? EDGE_WMASK : ZERO_BYTE);
			@(posedge ref_clk) ext_int_pin <= sel[0];
			cyc(8);
			// Global enable on, pin enable off: no vector may follow
			wr_reg(ADDR_INT_CONTROL, 8'h82);
			wr_reg(ADDR_PERIPHERAL_FLAGS_TWO, EV_MASK);
			@(posedge ref_clk) ext_int_pin <= !sel[0];
			cyc(8);
			rd_chk(ADDR_INT_CONTROL, 8'h80, "wrong edge");
			@(posedge ref_clk) ext_int_pin <= sel[0];
			cyc(8);
			rd_chk(ADDR_INT_CONTROL, 8'h82, "flag on edge");
			rd_chk(ADDR_PERIPHERAL_FLAGS_TWO, 8'h01, "edge event");
		end
		chk(vec_cnt, 0, "vector while disabled");
		$display("test edges done");
		wr_reg(ADDR_PERIPHERAL_ENABLE_TWO, 8'h01);
		rd_chk(ADDR_PERIPHERAL_ENABLE_TWO, 8'h01, "mask readback");
		chk(irq, 1'b1, "irq raised");
		wr_reg(ADDR_PERIPHERAL_ENABLE_TWO, ZERO_BYTE);
		cyc(2);
		chk(irq, 1'b0, "irq masked");
		wr_reg(ADDR_PERIPHERAL_ENABLE_TWO, 8'h01);
		wr_reg(ADDR_PERIPHERAL_FLAGS_TWO, EV_MASK);
		cyc(2);
		chk(irq, 1'b0, "irq cleared");
		$display("test irq done");
		wr_reg(ADDR_INT_CONTROL, 8'h92);
		pin_rise();
		chk(vec_cnt, 1, "vector taken");
		rd_chk(ADDR_INT_CONTROL, 8'h12, "flag kept");
		rd_chk(ADDR_PERIPHERAL_FLAGS_TWO, 8'h05, "edge and entry events");
		for (int i = 0; i < SH_NUM; i++)
		begin
			sh_a = {SHADOW_BANK, SHADOW_BASE + 7'(i)};
			rd_chk(sh_a, exp_q[0][8*i +: 8], "shadow");
		end
		idx = 3'($random(seed));
		rnd = 8'($random(seed));
		sh_a = {SHADOW_BANK, SHADOW_BASE + {4'h0, idx}};
		wr_reg(sh_a, rnd);
		exp_q[0][8*idx +: 8] = rnd;
		rd_chk(sh_a, rnd, "shadow write");
		wr_reg(ADDR_INT_CONTROL, 8'h12);
		ret_pulse();
		chk(exp_q.size(), 0, "context restored");
		rd_chk(ADDR_INT_CONTROL, 8'h90, "enable after return");
		$display("test context done");
		// Halt, then wake with and without global enable
		for (int g = 0; g < 2; g++)
		begin
			wr_reg(ADDR_INT_CONTROL, {g[0], 7'h12});
			n = vec_cnt;
			w = wake_cnt;
			retired = 1'b0;
			@(posedge ref_clk) go_halt <= 1'b1;
			@(posedge ref_clk) go_halt <= 1'b0;
			cyc(4);
			chk(wake_cnt, w, "woke without edge");
			pin_rise();
			cyc(4);
			chk(wake_cnt, w + 1, "pin wake");
			chk(vec_cnt, n + g, "vector after wake");
			if (g == 1)
			begin
				wr_reg(ADDR_INT_CONTROL, 8'h12);
				ret_pulse();
			end
		end
		$display("test wake done");
		wrap_up();
	end
endmodule
